// file: rtl/msense_pkg.sv
// Constants and decode helpers for the mode sense response builder.
package msense_pkg;

    // Command byte two field layout.
    localparam int SEL_MSB = 5;
    localparam int SET_MSB = 7;
    localparam int SET_LSB = 6;

    // Value sets chosen by the page value selector.
    localparam logic [1:0] SET_CURRENT    = 2'b00;
    localparam logic [1:0] SET_CHANGEABLE = 2'b01;
    localparam logic [1:0] SET_DEFAULT    = 2'b10;
    localparam logic [1:0] SET_SAVED      = 2'b11;

    // Page identifiers.
    localparam logic [5:0] PAGE_VENDOR = 6'h00;
    localparam logic [5:0] PAGE_ERR    = 6'h01;
    localparam logic [5:0] PAGE_DISC   = 6'h02;
    localparam logic [5:0] PAGE_FMT    = 6'h03;
    localparam logic [5:0] PAGE_GEOM   = 6'h04;
    localparam logic [5:0] SEL_ALL     = 6'h3f;

    // Parameter byte counts per page, header bytes excluded.
    localparam logic [7:0] LEN_ERR  = 8'h06;
    localparam logic [7:0] LEN_FMT  = 8'h16;
    localparam logic [7:0] LEN_GEOM = 8'h12;

    // Segment sizes and fixed field values.
    localparam logic [7:0] HDR_LAST     = 8'h03;
    localparam logic [7:0] BLK_LAST     = 8'h07;
    localparam logic [7:0] PHDR_BYTES   = 8'h02;
    localparam logic [7:0] LEN_FIXED    = 8'h0b;
    localparam logic [7:0] BLK_DESC_LEN = 8'h08;
    localparam logic [7:0] MEDIUM_TYPE  = 8'h00;
    localparam logic [7:0] DENSITY_CODE = 8'h00;
    localparam logic [7:0] ZERO_BYTE    = 8'h00;

    function automatic logic page_supported(input logic [5:0] id);
        return (id == PAGE_ERR) || (id == PAGE_FMT) || (id == PAGE_GEOM);
    endfunction

    function automatic logic [7:0] page_len(input logic [5:0] id);
        case (id)
            PAGE_ERR:  return LEN_ERR;
            PAGE_FMT:  return LEN_FMT;
            PAGE_GEOM: return LEN_GEOM;
            default:   return ZERO_BYTE;
        endcase
    endfunction

    // Page that follows id in an all-pages walk; vendor code ends it.
    function automatic logic [5:0] page_next(input logic [5:0] id);
        case (id)
            PAGE_ERR: return PAGE_FMT;
            PAGE_FMT: return PAGE_GEOM;
            default:  return PAGE_VENDOR;
        endcase
    endfunction

endpackage

// file: rtl/byte_stream_if.sv
// Valid/ready byte stream between the generator and the buffer.
interface byte_stream_if;
    logic       valid;
    logic       ready;
    logic [7:0] data;

    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface

// file: rtl/skid_buffer2.sv
// Two-entry buffer with registered outputs on both sides.
module skid_buffer2 (
    // Clock and reset
    input  wire logic    clk,
    input  wire logic    rst_n,
    // Streams
    byte_stream_if.sink  up,
    byte_stream_if.source dn,
    // Status
    output      logic    empty
);
    logic [7:0] head_ff;
    logic       head_vld_ff;
    logic [7:0] tail_ff;
    logic       tail_vld_ff;
    logic       take;
    logic       give;

    // Ready depends only on the spare entry, so no path runs from
    // the downstream ready back to the upstream ready.
    assign up.ready = !tail_vld_ff;
    assign dn.valid = head_vld_ff;
    assign dn.data  = head_ff;
    assign empty    = !head_vld_ff;
    assign take     = up.valid && !tail_vld_ff;
    assign give     = head_vld_ff && dn.ready;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            head_ff     <= 8'h00;
            head_vld_ff <= 1'b0;
            tail_ff     <= 8'h00;
            tail_vld_ff <= 1'b0;
        end else begin
            if (!head_vld_ff || give) begin
                if (tail_vld_ff) begin
                    head_ff     <= tail_ff;
                    head_vld_ff <= 1'b1;
                    tail_vld_ff <= 1'b0;
                end else begin
                    head_ff     <= up.data;
                    head_vld_ff <= take;
                end
            end else if (take) begin
                tail_ff     <= up.data;
                tail_vld_ff <= 1'b1;
            end
        end
    end
endmodule // skid_buffer2

// file: rtl/mode_sense_response_builder.sv
// Builds the mode sense parameter list and streams it out.
//
// Summary of operation
// - Top bits of byte two choose value set.
// - Low six bits of byte two select pages.
// - Single page 1, 3 or 4 returns just that page.
// - Selector 3Fh returns all pages, chosen set.
// - Disconnect page is never produced as supported.
// - Byte four gives the transfer byte limit.
// - Zero allocation sends nothing, no error.
// - Stop at allocation or response end.
// - Header, one block descriptor, then pages.
// - Page header: code, length of parameters.
// - Page code in low bits, then parameters.
// - Vendor page 00h never emitted.
// - Header byte zero is length minus one.
// - Medium type byte is always zero.
// - Write protect and reserved bits are zero.
// - Block descriptor length is always eight.
// - Density code is always zero.
// - Block count and reserved byte zero.
// - Block length, 24 bits, MSB first.
// - Page length is supported parameter count.
module mode_sense_response_builder
    import msense_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        ARST_N,
    // Command block fields
    input  wire logic        CMD_VALID,
    input  wire logic [7:0]  CMD_BYTE2,
    input  wire logic [7:0]  CMD_BYTE4,
    output      logic        CMD_READY,
    // Drive configuration
    input  wire logic [23:0] BLOCK_LEN,
    // Page value store lookup
    output      logic [5:0]  PG_ID,
    output      logic [1:0]  PG_SET,
    output      logic [7:0]  PG_IDX,
    input  wire logic [7:0]  PG_DATA,
    // Data in stream to the initiator
    output      logic [7:0]  DIN_DATA,
    output      logic        DIN_VALID,
    input  wire logic        DIN_READY,
    // Completion
    output      logic        DONE,
    output      logic        CHECK_COND,
    output      logic        BUSY
);

    typedef enum logic [2:0] {
        SEG_IDLE  = 3'b000,
        SEG_HDR   = 3'b001,
        SEG_BLK   = 3'b010,
        SEG_PAGE  = 3'b011,
        SEG_DRAIN = 3'b100
    } seg_t;

    logic [1:0] rst_sync_ff;
    logic       rst_n;

    seg_t       seg_ff;
    seg_t       nxt_seg;
    logic [7:0] idx_ff;
    logic [7:0] nxt_idx;
    logic [5:0] page_ff;
    logic [5:0] nxt_page;
    logic       all_ff;
    logic [1:0] set_ff;
    logic [7:0] alloc_ff;
    logic [7:0] cnt_ff;
    logic [7:0] slen_ff;
    logic       done_ff;
    logic       chk_ff;
    logic       busy_ff;
    logic       ready_ff;

    logic [5:0] cmd_sel;
    logic       cmd_ok;
    logic       gen_active;
    logic       push;
    logic       hit_alloc;
    logic       buf_empty;
    logic [7:0] gen_byte;
    logic [7:0] cur_len;

    byte_stream_if gen_s ();
    byte_stream_if out_s ();

    // Reset release is synchronised; assertion stays asynchronous.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // Only pages the drive implements and the 3Fh all-pages selector pass; 02h is refused here.
    assign cmd_sel = CMD_BYTE2[SEL_MSB:0];
    assign cmd_ok  = (cmd_sel == SEL_ALL) || page_supported(cmd_sel);

    assign gen_active = (seg_ff == SEG_HDR) || (seg_ff == SEG_BLK)
                        || (seg_ff == SEG_PAGE);
    assign push       = gen_active && gen_s.ready;
    assign hit_alloc  = (cnt_ff + 8'h01) == alloc_ff;
    assign cur_len    = page_len(page_ff);

    // Sense data length excludes its own byte.
    function automatic logic [7:0] resp_len(input logic all,
                                            input logic [5:0] id);
        logic [7:0] sum;
        sum = LEN_FIXED;
        if (all) begin
            sum = sum + LEN_ERR + LEN_FMT + LEN_GEOM
                  + PHDR_BYTES + PHDR_BYTES + PHDR_BYTES;
        end else begin
            sum = sum + page_len(id) + PHDR_BYTES;
        end
        return sum;
    endfunction

    // Byte at the current position of the response.
    always_comb begin
        gen_byte = ZERO_BYTE;
        case (seg_ff)
            SEG_HDR: begin
                case (idx_ff[1:0])
                    2'b00:   gen_byte = slen_ff;
                    2'b01:   gen_byte = MEDIUM_TYPE;
                    2'b10:   gen_byte = ZERO_BYTE;
                    default: gen_byte = BLK_DESC_LEN;
                endcase
            end
            SEG_BLK: begin
                case (idx_ff[2:0])
                    3'b000:  gen_byte = DENSITY_CODE;
                    3'b101:  gen_byte = BLOCK_LEN[23:16];
                    3'b110:  gen_byte = BLOCK_LEN[15:8];
                    3'b111:  gen_byte = BLOCK_LEN[7:0];
                    default: gen_byte = ZERO_BYTE;
                endcase
            end
            SEG_PAGE: begin
                if (idx_ff == 8'h00) begin
                    gen_byte = {2'b00, page_ff};
                end else if (idx_ff == 8'h01) begin
                    gen_byte = cur_len;
                end else begin
                    gen_byte = PG_DATA;
                end
            end
            default: gen_byte = ZERO_BYTE;
        endcase
    end

    assign gen_s.valid = gen_active;
    assign gen_s.data  = gen_byte;

    skid_buffer2 u_buf (
        .clk   (CLK),
        .rst_n (rst_n),
        .up    (gen_s),
        .dn    (out_s),
        .empty (buf_empty)
    );

    assign out_s.ready = DIN_READY;
    assign DIN_DATA    = out_s.data;
    assign DIN_VALID   = out_s.valid;

    // Walk of the response: header, descriptor, then pages in order.
    always_comb begin
        nxt_seg  = seg_ff;
        nxt_idx  = idx_ff;
        nxt_page = page_ff;
        case (seg_ff)
            SEG_IDLE: begin
                if (CMD_VALID && cmd_ok && (CMD_BYTE4 != 8'h00)) begin
                    nxt_seg  = SEG_HDR;
                    nxt_idx  = 8'h00;
                    nxt_page = (cmd_sel == SEL_ALL) ? PAGE_ERR : cmd_sel;
                end
            end
            SEG_HDR: begin
                if (push) begin
                    nxt_idx = idx_ff + 8'h01;
                    if (idx_ff == HDR_LAST) begin
                        nxt_seg = SEG_BLK;
                        nxt_idx = 8'h00;
                    end
                end
            end
            SEG_BLK: begin
                if (push) begin
                    nxt_idx = idx_ff + 8'h01;
                    if (idx_ff == BLK_LAST) begin
                        nxt_seg = SEG_PAGE;
                        nxt_idx = 8'h00;
                    end
                end
            end
            SEG_PAGE: begin
                if (push) begin
                    nxt_idx = idx_ff + 8'h01;
                    if (idx_ff == cur_len + 8'h01) begin
                        nxt_idx = 8'h00;
                        // The walk ends on the vendor code, never sent.
                        if (all_ff && (page_next(page_ff) != PAGE_VENDOR)) begin
                            nxt_page = page_next(page_ff);
                        end else begin
                            nxt_seg = SEG_DRAIN;
                        end
                    end
                end
            end
            SEG_DRAIN: begin
                if (buf_empty) begin
                    nxt_seg = SEG_IDLE;
                end
            end
            default: nxt_seg = SEG_IDLE;
        endcase
        if (push && hit_alloc) begin
            nxt_seg = SEG_DRAIN;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            seg_ff  <= SEG_IDLE;
            idx_ff  <= 8'h00;
            page_ff <= PAGE_VENDOR;
        end else begin
            seg_ff  <= nxt_seg;
            idx_ff  <= nxt_idx;
            page_ff <= nxt_page;
        end
    end

    // Command fields are captured once per command.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            all_ff   <= 1'b0;
            set_ff   <= SET_CURRENT;
            alloc_ff <= 8'h00;
            slen_ff  <= 8'h00;
        end else if (seg_ff == SEG_IDLE && CMD_VALID) begin
            all_ff   <= cmd_sel == SEL_ALL;
            set_ff   <= CMD_BYTE2[SET_MSB:SET_LSB];
            alloc_ff <= CMD_BYTE4;
            slen_ff  <= resp_len(cmd_sel == SEL_ALL, cmd_sel);
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 8'h00;
        end else if (seg_ff == SEG_IDLE) begin
            cnt_ff <= 8'h00;
        end else if (push) begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end

    // Status of the last command, held until the next one is taken.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            chk_ff <= 1'b0;
        end else if (seg_ff == SEG_IDLE && CMD_VALID) begin
            chk_ff <= !cmd_ok;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            done_ff <= 1'b0;
        end else begin
            // Refused and zero-length commands finish at once.
            done_ff <= (seg_ff == SEG_IDLE && CMD_VALID
                        && (!cmd_ok || CMD_BYTE4 == 8'h00))
                       || (seg_ff == SEG_DRAIN && buf_empty);
        end
    end

    // Ready has a flop of its own so the port carries no inverter.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            busy_ff  <= 1'b0;
            ready_ff <= 1'b1;
        end else begin
            busy_ff  <= nxt_seg != SEG_IDLE;
            ready_ff <= nxt_seg == SEG_IDLE;
        end
    end

    assign CMD_READY  = ready_ff;
    assign BUSY       = busy_ff;
    assign DONE       = done_ff;
    assign CHECK_COND = chk_ff;
    assign PG_ID      = page_ff;
    assign PG_SET     = set_ff;
    assign PG_IDX     = idx_ff;

endmodule // mode_sense_response_builder

// file: bench/msense_assertions.sv
// Port-level checks for the mode sense response builder.
module msense_assertions
    import msense_pkg::*;
(
    // Clock and reset
    input wire logic        CLK,
    input wire logic        ARST_N,
    // Command
    input wire logic        CMD_VALID,
    input wire logic [7:0]  CMD_BYTE2,
    input wire logic [7:0]  CMD_BYTE4,
    input wire logic        CMD_READY,
    input wire logic [23:0] BLOCK_LEN,
    // Page store
    input wire logic [5:0]  PG_ID,
    input wire logic [1:0]  PG_SET,
    input wire logic [7:0]  PG_IDX,
    input wire logic [7:0]  PG_DATA,
    // Data in and completion
    input wire logic [7:0]  DIN_DATA,
    input wire logic        DIN_VALID,
    input wire logic        DIN_READY,
    input wire logic        DONE,
    input wire logic        CHECK_COND,
    input wire logic        BUSY
);
    timeunit 1ns;
    timeprecision 1ps;
    logic take;
    logic good;
    assign take = CMD_VALID && CMD_READY;
    assign good = CMD_BYTE2[5:0] inside {PAGE_ERR, PAGE_FMT, PAGE_GEOM, SEL_ALL};
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);

    ready_idle_a: assert property (CMD_READY == !BUSY)
        else $error("command ready disagrees with busy");
    refuse_page_a: assert property (take && !good |=> DONE && CHECK_COND && !BUSY)
        else $error("bad page selector not refused");
    zero_alloc_a: assert property (take && CMD_BYTE4 == 8'h00 |=> DONE && !BUSY ##1 !DONE)
        else $error("zero allocation did not end at once");
    good_start_a: assert property (take && good && CMD_BYTE4 != 8'h00 |=> BUSY
        && {PG_SET, 6'h00} == ($past(CMD_BYTE2) & 8'hc0) ##1 DIN_VALID)
        else $error("accepted command did not start");
    check_clear_a: assert property (take && good |=> !CHECK_COND)
        else $error("check condition left on a good command");
    check_hold_a: assert property (CHECK_COND && !take |=> CHECK_COND)
        else $error("check condition dropped early");
    stall_hold_a: assert property (DIN_VALID && !DIN_READY |=> DIN_VALID && $stable(DIN_DATA))
        else $error("stalled byte changed");
    valid_busy_a: assert property (DIN_VALID |-> BUSY)
        else $error("data offered while idle");
    done_pulse_a: assert property (DONE |-> !BUSY ##1 !DONE)
        else $error("done not a single pulse");
    no_disc_a: assert property (BUSY |-> PG_ID != PAGE_DISC)
        else $error("disconnect page produced");
endmodule // msense_assertions

// file: bench/initiator_model.sv
// Initiator side model: takes data in bytes and stands in for the page store.
module initiator_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Stall pattern select
    input  wire logic       slow,
    // Page store lookup
    input  wire logic [5:0] pg_id,
    input  wire logic [1:0] pg_set,
    input  wire logic [7:0] pg_idx,
    output      logic [7:0] pg_data,
    // Data in stream
    input  wire logic [7:0] din_data,
    input  wire logic       din_valid,
    output      logic       din_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] phase_ff;
    logic [7:0] rx_q[$];

    // Every stored byte differs by set, page and offset, so a wrong lookup shows.
    assign pg_data = {pg_set, pg_id} + pg_idx;
    // A slow initiator takes one byte in three, which keeps the buffer full.
    assign din_ready = !slow || (phase_ff == 2'd0);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_ff <= 2'd0;
        end else begin
            phase_ff <= (phase_ff == 2'd2) ? 2'd0 : phase_ff + 2'd1;
        end
    end

    always @(posedge clk) begin
        if (din_valid && din_ready) begin
            rx_q.push_back(din_data);
        end
    end
endmodule // initiator_model

// file: bench/tb_top.sv
// Self-checking bench for the mode sense response builder.
module tb_top
    import msense_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        CLK = 1'b0, ARST_N = 1'b0, CMD_VALID = 1'b0, slow = 1'b0;
    logic [7:0]  CMD_BYTE2 = 8'h00, CMD_BYTE4 = 8'h00;
    logic [23:0] BLOCK_LEN = 24'h012345;
    logic        CMD_READY, DIN_VALID, DIN_READY, DONE, CHECK_COND, BUSY;
    logic [5:0]  PG_ID;
    logic [1:0]  PG_SET;
    logic [7:0]  PG_IDX, PG_DATA, DIN_DATA;
    logic [7:0]  exp_q[$];
    int          n_mismatch = 0, n_checks = 0;

    mode_sense_response_builder i_dut (.CLK(CLK), .ARST_N(ARST_N),
        .CMD_VALID(CMD_VALID), .CMD_BYTE2(CMD_BYTE2), .CMD_BYTE4(CMD_BYTE4),
        .CMD_READY(CMD_READY), .BLOCK_LEN(BLOCK_LEN), .PG_ID(PG_ID),
        .PG_SET(PG_SET), .PG_IDX(PG_IDX), .PG_DATA(PG_DATA),
        .DIN_DATA(DIN_DATA), .DIN_VALID(DIN_VALID), .DIN_READY(DIN_READY),
        .DONE(DONE), .CHECK_COND(CHECK_COND), .BUSY(BUSY));
    initiator_model i_host (.clk(CLK), .rst_n(ARST_N), .slow(slow),
        .pg_id(PG_ID), .pg_set(PG_SET), .pg_idx(PG_IDX), .pg_data(PG_DATA),
        .din_data(DIN_DATA), .din_valid(DIN_VALID), .din_ready(DIN_READY));

    initial begin
        forever #4 CLK = ~CLK;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic run_cmd(input logic [7:0] b2, input logic [7:0] b4);
        int k;
        i_host.rx_q.delete();
        @(posedge CLK);
        CMD_BYTE2 <= b2;
        CMD_BYTE4 <= b4;
        CMD_VALID <= 1'b1;
        @(posedge CLK);
        CMD_VALID <= 1'b0;
        for (k = 0; k < 3000 && DONE !== 1'b1; k++) @(negedge CLK);
        if (k == 3000) begin
            n_mismatch++;
            conclude();
        end
        check("busy", BUSY, 1'b0);
        check("command ready", CMD_READY, 1'b1);
    endtask

    task automatic add_page(input logic [5:0] id, input logic [1:0] set);
        logic [7:0] n;
        n = (id == PAGE_ERR) ? LEN_ERR : (id == PAGE_FMT) ? LEN_FMT : LEN_GEOM;
        exp_q.push_back({2'b00, id});
        exp_q.push_back(n);
        for (int i = 2; i < n + 2; i++) exp_q.push_back({set, id} + 8'(i));
    endtask

    // Builds the full list, then compares only the part the allocation admits.
    task automatic cmp_stream(input logic [7:0] b2, input logic [7:0] alloc);
        int n;
        exp_q = {8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        exp_q.push_back(BLOCK_LEN[23:16]);
        exp_q.push_back(BLOCK_LEN[15:8]);
        exp_q.push_back(BLOCK_LEN[7:0]);
        if (b2[5:0] == SEL_ALL) begin
            add_page(PAGE_ERR, b2[7:6]);
            add_page(PAGE_FMT, b2[7:6]);
            add_page(PAGE_GEOM, b2[7:6]);
        end else begin
            add_page(b2[5:0], b2[7:6]);
        end
        exp_q[0] = 8'(exp_q.size() - 1);
        n = (alloc < exp_q.size()) ? alloc : exp_q.size();
        check("check condition", CHECK_COND, 1'b0);
        check("byte count", i_host.rx_q.size(), n);
        for (int i = 0; i < n && i < i_host.rx_q.size(); i++) begin
            check("data byte", i_host.rx_q[i], exp_q[i]);
        end
    endtask

    task automatic t_single();
        logic [5:0] sel[3] = '{PAGE_ERR, PAGE_FMT, PAGE_GEOM};
        foreach (sel[i]) begin
            run_cmd({2'b00, sel[i]}, 8'hff);
            cmp_stream({2'b00, sel[i]}, 8'hff);
        end
        $display("test single page done");
    endtask

    task automatic t_all_sets();
        @(posedge CLK);
        slow <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            run_cmd({2'(s), SEL_ALL}, 8'hff);
            cmp_stream({2'(s), SEL_ALL}, 8'hff);
        end
        @(posedge CLK);
        slow <= 1'b0;
        $display("test all pages done");
    endtask

    task automatic t_refuse();
        logic [5:0] sel[5] = '{PAGE_VENDOR, PAGE_DISC, 6'h05, 6'h3e, PAGE_DISC};
        foreach (sel[i]) begin
            run_cmd({2'b00, sel[i]}, (i == 4) ? 8'h00 : 8'hff);
            check("refused", CHECK_COND, 1'b1);
            check("refused count", i_host.rx_q.size(), 0);
        end
        $display("test refused pages done");
    endtask

    task automatic t_trunc();
        logic [7:0] len[7] = '{8'h00, 8'h01, 8'h04, 8'h0c, 8'h0d, 8'h3f, 8'h40};
        foreach (len[i]) begin
            run_cmd({SET_SAVED, SEL_ALL}, len[i]);
            cmp_stream({SET_SAVED, SEL_ALL}, len[i]);
        end
        $display("test truncation done");
    endtask

    initial begin
        repeat (10) @(posedge CLK);
        ARST_N <= 1'b1;
        repeat (3) @(posedge CLK);
        t_single();
        t_all_sets();
        t_refuse();
        t_trunc();
        conclude();
    end
endmodule // tb_top

bind mode_sense_response_builder msense_assertions i_chk (.CLK(CLK),
    .ARST_N(ARST_N), .CMD_VALID(CMD_VALID), .CMD_BYTE2(CMD_BYTE2),
    .CMD_BYTE4(CMD_BYTE4), .CMD_READY(CMD_READY), .BLOCK_LEN(BLOCK_LEN),
    .PG_ID(PG_ID), .PG_SET(PG_SET), .PG_IDX(PG_IDX), .PG_DATA(PG_DATA),
    .DIN_DATA(DIN_DATA), .DIN_VALID(DIN_VALID), .DIN_READY(DIN_READY),
    .DONE(DONE), .CHECK_COND(CHECK_COND), .BUSY(BUSY));
